// ### hdl/ptr_test_ctrl.v
`timescale 1ns/1ps
`include "ptr_defs.vh"

module ptr_test_ctrl (
    // Clock and reset
    input  wire        sys_clk,
    input  wire        rst,
    input  wire        ce,
    // Management register port
    input  wire [4:0]  reg_addr,
    input  wire [15:0] reg_wdata,
    input  wire        reg_we,
    input  wire        reg_re,
    output reg  [15:0] reg_rdata,
    // Self-test status from the packet checker
    input  wire        selftest_start,
    input  wire        selftest_active,
    input  wire        nibble_error,
    // Line-side context
    input  wire        ten_meg_mode,
    input  wire        babble_guard_off,
    input  wire        seq_done,
    // Line driver controls
    output reg         nonstop_prbs_transmit,
    output reg         seq_start,
    output reg  [1:0]  seq_kind,
    output reg         tone_on,
    output reg         jabber_enable,
    output reg         core_reset
);

    localparam [9:0] GAP_SHORT = `PTR_GAP_SHORT_CYC - 10'h001;
    localparam [9:0] GAP_LONG  = `PTR_GAP_LONG_CYC - 10'h001;
    localparam [9:0] SRST_LEN  = `PTR_SRESET_CYC - 10'h001;
    localparam [9:0] CNT_ZERO  = 10'h000;

    localparam [1:0] ST_IDLE = 2'h0;
    localparam [1:0] ST_RUN  = 2'h1;
    localparam [1:0] ST_GAP  = 2'h2;
    localparam [1:0] ST_TONE = 2'h3;

    reg [7:0]  tally_reg;
    reg [7:0]  low_ctl_reg;
    reg        soft_reset_reg;
    reg [9:0]  srst_cnt_reg;
    reg [1:0]  state_reg;
    reg [1:0]  state_next;
    reg [9:0]  gap_cnt_reg;
    reg [9:0]  gap_cnt_next;
    reg        start_next;

    wire wr_drv   = reg_we && (reg_addr == `PTR_ADDR_DRV_TEST);
    wire wr_extra = reg_we && (reg_addr == `PTR_ADDR_EXTRA_CTL);
    wire patt_on  = low_ctl_reg[`PTR_BIT_PATT_ON];
    wire gap_long = low_ctl_reg[`PTR_BIT_GAP_SEL];
    wire [1:0] choice = low_ctl_reg[`PTR_SEL_HI:`PTR_SEL_LO];
    wire is_tone  = (choice == `PTR_PAT_TONE);
    wire tally_step = selftest_active && nibble_error && (tally_reg != `PTR_TALLY_MAX);
    // Only the soft-reset bit is backed by storage
    wire [15:0] extra_rd = {{(`PTR_DATA_W - 1 - `PTR_BIT_SOFT_RESET){1'b0}}, soft_reset_reg,
                            {`PTR_BIT_SOFT_RESET{1'b0}}};

    // ************************************************************
    // Driver test control byte
    // ************************************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            low_ctl_reg <= `PTR_RESET_LOW8;
        end else if (ce && wr_drv) begin
            // Reserved bits 7:6 and 3 kept as plain storage
            low_ctl_reg <= reg_wdata[`PTR_LOW_HI:0];
        end
    end

    // ************************************************************
    // Self-test error tally
    // ************************************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            tally_reg <= `PTR_RESET_TALLY;
        end else if (ce) begin
            // restart clears tally
            // Restart wins over an error in the same cycle
            if (selftest_start) begin
                tally_reg <= `PTR_RESET_TALLY;
            end else if (tally_step) begin
                tally_reg <= tally_reg + 8'h01;
            end
        end
    end

    // ************************************************************
    // Self-clearing soft reset
    // ************************************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            soft_reset_reg <= 1'b0;
            srst_cnt_reg   <= CNT_ZERO;
        end else if (ce) begin
            if (soft_reset_reg) begin
                if (srst_cnt_reg == SRST_LEN) begin
                    soft_reset_reg <= 1'b0;
                    srst_cnt_reg   <= CNT_ZERO;
                end else begin
                    srst_cnt_reg <= srst_cnt_reg + 10'h001;
                end
            // Request while busy is dropped, not queued
            end else if (wr_extra && reg_wdata[`PTR_BIT_SOFT_RESET]) begin
                soft_reset_reg <= 1'b1;
            end
        end
    end

    // ************************************************************
    // Read data
    // ************************************************************
    always @(posedge sys_clk) begin
        if (rst) begin
            reg_rdata <= `PTR_RESET_RDATA;
        end else if (ce && reg_re) begin
            case (reg_addr)
                `PTR_ADDR_DRV_TEST: begin
                    reg_rdata <= {tally_reg, low_ctl_reg};
                end
                `PTR_ADDR_EXTRA_CTL: begin
                    reg_rdata <= extra_rd;
                end
                default: begin
                    reg_rdata <= `PTR_RESET_RDATA;
                end
            endcase
        end
    end

    // ************************************************************
    // Pattern sequencer
    // ************************************************************
    always @* begin
        state_next   = state_reg;
        gap_cnt_next = gap_cnt_reg;
        start_next   = 1'b0;
        case (state_reg)
            ST_IDLE: begin
                if (patt_on) begin
                    if (is_tone) begin
                        state_next = ST_TONE;
                    end else begin
                        start_next = 1'b1;
                        state_next = ST_RUN;
                    end
                end
            end
            ST_RUN: begin
                if (seq_done) begin
                    gap_cnt_next = gap_long ? GAP_LONG : GAP_SHORT;
                    state_next   = ST_GAP;
                end
            end
            ST_GAP: begin
                if (gap_cnt_reg == CNT_ZERO) begin
                    start_next = 1'b1;
                    state_next = ST_RUN;
                end else begin
                    gap_cnt_next = gap_cnt_reg - 10'h001;
                end
            end
            ST_TONE: begin
                if (!is_tone) begin
                    state_next = ST_IDLE;
                end
            end
            default: begin
                state_next = ST_IDLE;
            end
        endcase
        // Leaving or entering tone restarts cleanly
        if (!patt_on || (is_tone && state_reg != ST_TONE && state_reg != ST_IDLE)) begin
            state_next = ST_IDLE;
            start_next = 1'b0;
        end
    end

    // ************************************************************
    // Output stage
    // ************************************************************
    // Every line control leaves from a flop, so the driver sees no glitches
    always @(posedge sys_clk) begin
        if (rst) begin
            state_reg             <= ST_IDLE;
            gap_cnt_reg           <= CNT_ZERO;
            seq_start             <= 1'b0;
            seq_kind              <= `PTR_PAT_EOP0;
            tone_on               <= 1'b0;
            nonstop_prbs_transmit <= 1'b0;
            jabber_enable         <= 1'b1;
            core_reset            <= 1'b0;
        end else if (ce) begin
            core_reset <= soft_reset_reg;
            if (soft_reset_reg) begin
                state_reg             <= ST_IDLE;
                gap_cnt_reg           <= CNT_ZERO;
                seq_start             <= 1'b0;
                tone_on               <= 1'b0;
                nonstop_prbs_transmit <= 1'b0;
            end else begin
                state_reg   <= state_next;
                gap_cnt_reg <= gap_cnt_next;
                seq_start   <= start_next;
                seq_kind    <= choice;
                tone_on     <= (state_next == ST_TONE);
                // endless PRBS; jabber off only at 10 Mb with babble_guard_off set
                nonstop_prbs_transmit <= low_ctl_reg[`PTR_BIT_NONSTOP] && selftest_active;
            end
            jabber_enable <= !(ten_meg_mode && babble_guard_off);
        end
    end

endmodule // ptr_test_ctrl

// ### include/ptr_defs.vh
`ifndef PTR_DEFS_VH
`define PTR_DEFS_VH

// ************************************************************
// Register map
// ************************************************************
`define PTR_ADDR_W          5
`define PTR_ADDR_DRV_TEST   5'h1b
`define PTR_ADDR_EXTRA_CTL  5'h1c
`define PTR_DATA_W          16
`define PTR_RESET_LOW8      8'h00
`define PTR_RESET_TALLY     8'h00
`define PTR_RESET_RDATA     16'h0000
`define PTR_TALLY_MAX       8'hff

// ************************************************************
// Field positions
// ************************************************************
`define PTR_TALLY_HI        15
`define PTR_TALLY_LO        8
`define PTR_LOW_HI          7
`define PTR_BIT_NONSTOP     5
`define PTR_BIT_PATT_ON     4
`define PTR_BIT_GAP_SEL     2
`define PTR_SEL_HI          1
`define PTR_SEL_LO          0
`define PTR_BIT_SOFT_RESET  9

// ************************************************************
// Pattern choices
// ************************************************************
`define PTR_PAT_EOP0        2'h0
`define PTR_PAT_EOP1        2'h1
`define PTR_PAT_LINK_PULSE  2'h2
`define PTR_PAT_TONE        2'h3

// ************************************************************
// Timing
// ************************************************************
`define PTR_CLK_PERIOD_NS   20
`define PTR_GAP_SHORT_NS    10000
`define PTR_GAP_LONG_NS     15000
`define PTR_SRESET_NS       1000
// Counts at the 20 ns clock, sized for the 10-bit counters
`define PTR_GAP_SHORT_CYC   10'h1f4
`define PTR_GAP_LONG_CYC    10'h2ee
`define PTR_SRESET_CYC      10'h032
`define PTR_CNT_W           10

`endif

// ### tb/phy_test_pattern_and_soft_reset_test.sv
`timescale 1ns/1ps
module phy_test_pattern_and_soft_reset_test;
    reg         sys_clk = 1'b0, rst = 1'b1, ce = 1'b1, reg_we = 1'b0, reg_re = 1'b0;
    reg         selftest_start = 1'b0, selftest_active = 1'b0, nibble_error = 1'b0;
    reg         ten_meg_mode = 1'b0, babble_guard_off = 1'b0;
    reg  [4:0]  reg_addr = 5'h00;
    reg  [15:0] reg_wdata = 16'h0000;
    wire [15:0] reg_rdata;
    wire [1:0]  seq_kind;
    wire        seq_done, nonstop_prbs_transmit, seq_start, tone_on, jabber_enable, core_reset;
    integer     err_count = 0, checks_done = 0, i, n;
    ptr_test_ctrl uut (
        .sys_clk               (sys_clk),
        .rst                   (rst),
        .ce                    (ce),
        .reg_addr              (reg_addr),
        .reg_wdata             (reg_wdata),
        .reg_we                (reg_we),
        .reg_re                (reg_re),
        .reg_rdata             (reg_rdata),
        .selftest_start        (selftest_start),
        .selftest_active       (selftest_active),
        .nibble_error          (nibble_error),
        .ten_meg_mode          (ten_meg_mode),
        .babble_guard_off      (babble_guard_off),
        .seq_done              (seq_done),
        .nonstop_prbs_transmit (nonstop_prbs_transmit),
        .seq_start             (seq_start),
        .seq_kind              (seq_kind),
        .tone_on               (tone_on),
        .jabber_enable         (jabber_enable),
        .core_reset            (core_reset)
    );
    ptr_line_model #(.DLY(20)) line (
        .sys_clk   (sys_clk),
        .seq_start (seq_start),
        .seq_done  (seq_done)
    );
    always #10 sys_clk = ~sys_clk;
    task conclude;
        $display("Checks %0d errors %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task tick(input integer k);
        repeat (k) @(posedge sys_clk);
        #2;
    endtask
    task chk(input [15:0] got, input [15:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            err_count = err_count + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task lim;
        if (n >= 1000) begin
            err_count = err_count + 1;
            conclude;
        end
    endtask
    task wr(input [4:0] a, input [15:0] v);
        reg_addr = a;
        reg_wdata = v;
        reg_we = 1'b1;
        tick(1);
        reg_we = 1'b0;
    endtask
    task rd(input [4:0] a, input [15:0] exp);
        reg_addr = a;
        reg_re = 1'b1;
        tick(1);
        reg_re = 1'b0;
        tick(1);
        chk(reg_rdata, exp);
    endtask
    task wstart;
        for (n = 0; seq_start !== 1'b1 && n < 1000; n = n + 1) tick(1);
        lim;
    endtask
    task t_tally;
        ten_meg_mode = 1'b1;
        babble_guard_off = 1'b1;
        selftest_active = 1'b1;
        selftest_start = 1'b1;
        tick(1);
        selftest_start = 1'b0;
        nibble_error = 1'b1;
        tick(3);
        nibble_error = 1'b0;
        rd(5'h1b, 16'h0300);
        // Clock enable low must freeze the tally
        ce = 1'b0;
        nibble_error = 1'b1;
        tick(4);
        ce = 1'b1;
        nibble_error = 1'b0;
        rd(5'h1b, 16'h0300);
        nibble_error = 1'b1;
        tick(300);
        nibble_error = 1'b0;
        rd(5'h1b, 16'hff00);
        wr(5'h1b, 16'h12e8);
        rd(5'h1b, 16'hffe8);
        chk(nonstop_prbs_transmit, 16'h0001);
        chk(jabber_enable, 16'h0000);
        selftest_start = 1'b1;
        tick(1);
        selftest_start = 1'b0;
        rd(5'h1b, 16'h00e8);
        selftest_active = 1'b0;
        ten_meg_mode = 1'b0;
        tick(2);
        chk(nonstop_prbs_transmit, 16'h0000);
    endtask
    task t_soft;
        selftest_active = 1'b1;
        tick(2);
        chk(nonstop_prbs_transmit, 16'h0001);
        wr(5'h1c, 16'hffff);
        rd(5'h1c, 16'h0200);
        chk(core_reset, 16'h0001);
        chk(nonstop_prbs_transmit, 16'h0000);
        for (n = 0; core_reset === 1'b1 && n < 1000; n = n + 1) tick(1);
        lim;
        chk(nonstop_prbs_transmit, 16'h0001);
        selftest_active = 1'b0;
        rd(5'h1c, 16'h0000);
        rd(5'h1b, 16'h00e8);
    endtask
    task t_pattern;
        for (i = 0; i < 6; i = i + 1) begin
            wr(5'h1b, 16'(16 + 4 * (i / 3) + i % 3));
            wstart;
            chk(seq_kind, 16'(i % 3));
            for (n = 0; seq_done !== 1'b1 && n < 1000; n = n + 1) tick(1);
            lim;
            wstart;
            chk(16'(n), i < 3 ? 16'd501 : 16'd751);
            wr(5'h1b, 16'h0000);
            // Let the line model finish before the next setup
            tick(30);
        end
        wr(5'h1b, 16'h0013);
        tick(2);
        chk(tone_on, 16'h0001);
        wr(5'h1b, 16'h0000);
        tick(2);
        chk(tone_on, 16'h0000);
    endtask
    task t_hwreset;
        wr(5'h1b, 16'h0033);
        selftest_active = 1'b1;
        nibble_error = 1'b1;
        tick(2);
        nibble_error = 1'b0;
        chk(tone_on, 16'h0001);
        wr(5'h1c, 16'h0200);
        // Mid-run reset with tally, control byte and soft bit all set
        rst = 1'b1;
        selftest_active = 1'b0;
        tick(2);
        rst = 1'b0;
        chk(tone_on, 16'h0000);
        chk(core_reset, 16'h0000);
        rd(5'h1b, 16'h0000);
        rd(5'h1c, 16'h0000);
    endtask
    initial begin
        tick(8);
        rst = 1'b0;
        rd(5'h1b, 16'h0000);
        rd(5'h1c, 16'h0000);
        t_tally;
        t_soft;
        t_pattern;
        t_hwreset;
        conclude;
    end
endmodule // phy_test_pattern_and_soft_reset_test

// ### tb/ptr_line_model.sv
`timescale 1ns/1ps
module ptr_line_model #(
    parameter DLY = 20
) (
    // Line driver handshake
    input  wire sys_clk,
    input  wire seq_start,
    output reg  seq_done
);
    initial seq_done = 1'b0;
    // Busy lines miss starts, as a real driver would
    always @(posedge sys_clk) begin
        if (seq_start) begin
            repeat (DLY) @(posedge sys_clk);
            seq_done <= 1'b1;
            @(posedge sys_clk);
            seq_done <= 1'b0;
        end
    end
endmodule // ptr_line_model

// ### tb/ptr_test_ctrl_properties.sv
`timescale 1ns/1ps
module ptr_test_ctrl_properties (
    // Clock, reset and register port
    input wire        sys_clk,
    input wire        rst,
    input wire        ce,
    input wire        reg_re,
    input wire [4:0]  reg_addr,
    input wire [15:0] reg_rdata,
    // Context inputs
    input wire        selftest_active,
    input wire        ten_meg_mode,
    input wire        babble_guard_off,
    input wire        seq_done,
    // Line controls
    input wire        nonstop_prbs_transmit,
    input wire        seq_start,
    input wire        tone_on,
    input wire        jabber_enable,
    input wire        core_reset
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    // Read data is registered, valid one edge after the strobe
    property p_rsvd; ce && reg_re && reg_addr == 5'h1c |=> (reg_rdata & 16'hfdff) == 16'h0000;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved bits set");
    property p_nonstop; nonstop_prbs_transmit |-> $past(selftest_active); endproperty
    a_nonstop: assert property (p_nonstop) else $error("nonstop without test");
    property p_soft_quiet; core_reset |-> !seq_start && !nonstop_prbs_transmit; endproperty
    a_soft_quiet: assert property (p_soft_quiet) else $error("activity in reset");
    property p_soft_len; $rose(core_reset) |=> core_reset [*8]; endproperty
    a_soft_len: assert property (p_soft_len) else $error("soft reset too short");
    property p_tone; tone_on |-> !seq_start; endproperty
    a_tone: assert property (p_tone) else $error("start during tone");
    property p_jab_off; ce && ten_meg_mode && babble_guard_off |=> !jabber_enable; endproperty
    a_jab_off: assert property (p_jab_off) else $error("jabber still on");
    property p_jab_on; ce && !ten_meg_mode |=> jabber_enable; endproperty
    a_jab_on: assert property (p_jab_on) else $error("jabber off at 100");
    property p_pulse; seq_start |=> !seq_start; endproperty
    a_pulse: assert property (p_pulse) else $error("start too long");
    property p_gap; seq_done |=> !seq_start [*8]; endproperty
    a_gap: assert property (p_gap) else $error("gap too short");
    c_start: cover property (seq_start);
    c_tone: cover property (tone_on);
    c_soft: cover property ($rose(core_reset));
endmodule // ptr_test_ctrl_properties
bind ptr_test_ctrl ptr_test_ctrl_properties chk_i (
    .sys_clk               (sys_clk),
    .rst                   (rst),
    .ce                    (ce),
    .reg_re                (reg_re),
    .reg_addr              (reg_addr),
    .reg_rdata             (reg_rdata),
    .selftest_active       (selftest_active),
    .ten_meg_mode          (ten_meg_mode),
    .babble_guard_off      (babble_guard_off),
    .seq_done              (seq_done),
    .nonstop_prbs_transmit (nonstop_prbs_transmit),
    .seq_start             (seq_start),
    .tone_on               (tone_on),
    .jabber_enable         (jabber_enable),
    .core_reset            (core_reset)
);
